// File: logic/scmc_cycle_gen.sv
// Machine cycle generator: four states per cycle and instruction length.
// Assumes tick is a one-cycle main clock pulse on clk.
module scmc_cycle_gen import scmc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic instrStart,
   input wire logic [3:0] instrLen,
   output logic [1:0] mcState,
   output logic mcLast,
   output logic instrDone
);
   logic [3:0] left_r;
   logic [3:0] lenClamped;

   assign mcLast = tick && (mcState == MC_LAST);
   assign lenClamped = (instrLen < INSTR_MIN) ? INSTR_MIN :
                       (instrLen > INSTR_MAX) ? INSTR_MAX : instrLen;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mcState <= '0;
      end else if (tick) begin
         mcState <= mcState + 1'b1; // RULE8
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         left_r <= '0;
         instrDone <= 1'b0;
      end else begin
         instrDone <= mcLast && (left_r == 4'h1);
         if (instrStart) begin
            left_r <= lenClamped; // RULE9
         end else if (mcLast && left_r != 4'h0) begin
            left_r <= left_r - 1'b1;
         end
      end
   end

   state_step_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      tick |=> (mcState == $past(mcState) + 2'h1))
      else $error("machine state did not step");
   state_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
      !tick |=> (mcState == $past(mcState)))
      else $error("machine state moved without tick");
endmodule

// File: logic/scmc_divider.sv
// Two-stage prescaler and 21-stage divider chain.
// Assumes clear and all enables are single-cycle terms on clk.
module scmc_divider import scmc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic preEn,
   input wire logic stage7Sel,
   input wire logic fsTick,
   output logic [DIV_W-1:0] divBits
);
   logic [PRE_W-1:0] pre_r;
   logic [DIV_LOW_W-1:0] low_r;
   logic [DIV_W-DIV_LOW_W-1:0] high_r;
   logic preCarry;
   logic lowCarry;
   logic s7In;

   assign preCarry = preEn && (pre_r == '1);
   assign lowCarry = preCarry && (low_r == '1);
   // Stage 7 input is either the sixth stage carry or the slow tick
   assign s7In = stage7Sel ? fsTick : lowCarry; // RULE3

   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         pre_r <= '0; // RULE2
      end else if (preEn) begin
         pre_r <= pre_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         low_r <= '0; // RULE2
      end else if (preCarry) begin
         low_r <= low_r + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || clear) begin
         high_r <= '0; // RULE2
      end else if (s7In) begin
         high_r <= high_r + 1'b1;
      end
   end

   assign divBits = {high_r, low_r}; // RULE1

   stage_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
      clear |=> (divBits == '0))
      else $error("divider not cleared");
endmodule

// File: logic/scmc_pkg.sv
// Constants, field layout and types of the system clock and mode controller.
// Assumes a single 25 MHz system clock and an 8-bit register port.
package scmc_pkg;
   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] ADDR_CTRL1 = 4'h0;
   localparam logic [3:0] ADDR_CTRL2 = 4'h1;
   localparam logic [3:0] ADDR_TBCTRL = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int C1_STOP = 7;
   localparam int C1_RETSLOW = 5;
   localparam int C2_FASTEN = 7;
   localparam int C2_SLOWEN = 6;
   localparam int C2_MCS = 5;
   localparam int C2_DOZE = 4;
   localparam int C2_HALT = 2;
   localparam int TB_EN = 7;
   localparam int TB_S7SEL = 6;
   localparam int TB_SEL_LSB = 0;
   localparam int TB_SEL_W = 3;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h80;
   localparam logic [7:0] TBCTRL_RST = 8'h00;
   // ---------------------------------------------------------------
   // Divider shape and taps
   // ---------------------------------------------------------------
   localparam int PRE_W = 2;
   localparam int DIV_W = 21;
   localparam int DIV_LOW_W = 6;
   localparam logic [4:0] TB_TAP_BASE = 5'h0C;
   localparam logic [4:0] DVO_TAP = 5'h0A;
   localparam logic [4:0] WARM_TAP = 5'h0E;
   localparam logic [3:0] INSTR_MIN = 4'h1;
   localparam logic [3:0] INSTR_MAX = 4'hA;
   localparam logic [1:0] MC_LAST = 2'h3;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } scmc_bus_t;
   typedef struct packed {
      logic cpu;
      logic wdt;
      logic timebase_timer;
      logic periph;
   } scmc_clken_t;
   typedef enum logic [3:0] {
      M_FAST_RUN_SINGLE,
      M_FAST_DOZE_SINGLE,
      M_TB_HALT_SINGLE,
      M_FAST_RUN_DUAL,
      M_FAST_DOZE_DUAL,
      M_SLOW_RUN,
      M_SLOW_SLEEP,
      M_STOP,
      M_WARM
   } scmc_mode_t;
endpackage

// File: logic/scmc_top.sv
// System clock and operating mode controller top level.
// Assumes clk is the fast oscillator clock, irqReq is already on clk and
// the slow oscillator and stop release arrive as asynchronous pins.
//
// Function
// [RULE1] Clocks come from a 2-stage prescaler and a 21-stage divider.
// [RULE2] Reset and stop entry or release clear prescaler and divider.
// [RULE3] Stage 7 input depends on mode, main clock select and source select.
// [RULE4] Slow run and slow sleep feed stage 7 from the slow clock.
// [RULE5] Warm-up after stop from fast run feeds stage 7 from stage 6.
// [RULE6] Software never sets the stage 7 source in single-clock mode.
// [RULE7] Software never sets the stage 7 source before the slow clock is stable.
// [RULE8] A machine cycle is four states, one main clock each.
// [RULE9] Instructions take one to ten machine cycles.
// [RULE10] Single-clock mode runs fast clock only; slow pins are ports.
// [RULE11] Reset leaves the device in fast run single mode.
// [RULE12] Doze request halts CPU and watchdog; peripherals keep running.
// [RULE13] Any interrupt request ends doze and returns to fast run.
// [RULE14] Wake with master enable services the interrupt, else resumes.
// [RULE15] Halt bit stops CPU and all peripherals but the timebase.
// [RULE16] Falling edge of the timebase source ends halt.
// [RULE17] Halt ignores timebase enable; service needs all three enables.
// [RULE18] Halt entered with timebase enabled sets the timebase interrupt.
// [RULE19] Dual mode main clock is fast in run or doze, slow otherwise.
// [RULE20] Dual mode runs both oscillators; slow pins are not ports.
// [RULE21] Software enables the slow oscillator early for dual mode.
// [RULE22] Fast run dual runs the CPU from the fast clock.
// [RULE23] Main clock select moves between fast run dual and slow run.
// [RULE24] Slow run with fast oscillator off stops stages one to six.
// [RULE25] Mode changes only on machine cycle boundaries; stop and warm-up here change mode on any clock.
// [RULE26] The timebase edge is synchronised before releasing halt.
//
// Decided for this implementation: the address map and the address-and-strobe port.
module scmc_top import scmc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire scmc_bus_t bus,
   output logic [DATA_W-1:0] rdata,
   input wire logic slowOscIn,
   input wire logic stopReleaseIn,
   input wire logic irqReq,
   input wire logic master_interrupt_enable,
   input wire logic tbIrqEnable,
   input wire logic instrStart,
   input wire logic [3:0] instrLen,
   output scmc_mode_t mode,
   output scmc_clken_t clkEn,
   output logic mainTick,
   output logic [1:0] mcState,
   output logic instrDone,
   output logic fastOscEnable,
   output logic slowOscEnable,
   output logic slowPinsAsPort,
   output logic dividerPulseOut,
   output logic timebaseIrqSet,
   output logic tbService,
   output logic wakeService,
   output logic wakeResume
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0] ctrl1_r;
   logic [7:0] ctrl2_r;
   logic [7:0] tbctrl_r;
   logic fsS1_r, fsS2_r, fsS3_r;
   logic relS1_r, relS2_r;
   logic tbS1_r, tbS2_r, tbS3_r;
   logic fsTick;
   logic tbFall;
   logic [DIV_W-1:0] divBits;
   logic [4:0] tapIdx;
   logic stage7Sel;
   logic preEn;
   logic divClr_r;
   logic tickNow;
   logic mcLast;
   logic advance;
   scmc_mode_t modeNxt;
   scmc_mode_t retMode_r;
   logic fromFast_r;
   logic haltTbEn_r;
   logic dozeClr, haltClr, stopClr;
   logic slowMode, fastOff;
   logic wr1, wr2, wrTb;

   assign wr1 = bus.wr && (bus.addr == ADDR_CTRL1);
   assign wr2 = bus.wr && (bus.addr == ADDR_CTRL2);
   assign wrTb = bus.wr && (bus.addr == ADDR_TBCTRL);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fsS1_r <= 1'b0;
         fsS2_r <= 1'b0;
         fsS3_r <= 1'b0;
      end else begin
         fsS1_r <= slowOscIn;
         fsS2_r <= fsS1_r;
         fsS3_r <= fsS2_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         relS1_r <= 1'b0;
         relS2_r <= 1'b0;
      end else begin
         relS1_r <= stopReleaseIn;
         relS2_r <= relS1_r;
      end
   end

   // Slow oscillator only counts while it is enabled
   assign fsTick = ctrl2_r[C2_SLOWEN] && fsS2_r && !fsS3_r;

   // ---------------------------------------------------------------
   // Timebase source edge
   // ---------------------------------------------------------------
   assign tapIdx = TB_TAP_BASE + {2'b00, tbctrl_r[TB_SEL_LSB +: TB_SEL_W]};

   // Two stages before the edge detector; the tap may follow the slow pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tbS1_r <= 1'b0;
         tbS2_r <= 1'b0;
         tbS3_r <= 1'b0;
      end else begin
         tbS1_r <= divBits[tapIdx]; // RULE26
         tbS2_r <= tbS1_r;
         // Held until a cycle boundary so a mid-cycle edge is not lost
         if (advance) tbS3_r <= tbS2_r; // RULE16
      end
   end

   assign tbFall = !tbS2_r && tbS3_r; // RULE26

   // ---------------------------------------------------------------
   // Divider control
   // ---------------------------------------------------------------
   assign slowMode = (mode == M_SLOW_RUN) || (mode == M_SLOW_SLEEP);
   assign fastOff = !ctrl2_r[C2_FASTEN];

   always_comb begin
      if (slowMode) begin
         stage7Sel = 1'b1; // RULE4
      end else if (mode == M_WARM && fromFast_r) begin
         stage7Sel = 1'b0; // RULE5
      end else begin
         stage7Sel = tbctrl_r[TB_S7SEL]; // RULE3
      end
   end

   // Stages one to six idle whenever the fast oscillator is down
   assign preEn = (mode != M_STOP) && !(slowMode && fastOff); // RULE24

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divClr_r <= 1'b0;
      end else begin
         divClr_r <= advance && ((modeNxt == M_STOP) != (mode == M_STOP));
      end
   end

   scmc_divider u_div (
      .clk(clk),
      .rst_n(rst_n),
      .clear(divClr_r), // RULE2
      .preEn(preEn),
      .stage7Sel(stage7Sel),
      .fsTick(fsTick),
      .divBits(divBits)
   );

   // ---------------------------------------------------------------
   // Main clock and machine cycle
   // ---------------------------------------------------------------
   always_comb begin
      case (mode)
         M_SLOW_RUN, M_SLOW_SLEEP: tickNow = fsTick; // RULE19
         M_STOP: tickNow = 1'b0;
         default: tickNow = 1'b1; // RULE10 RULE22
      endcase
   end

   scmc_cycle_gen u_cyc (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tickNow),
      .instrStart(instrStart),
      .instrLen(instrLen),
      .mcState(mcState),
      .mcLast(mcLast),
      .instrDone(instrDone)
   );

   // Switching mid-cycle would hand a truncated state to the core
   assign advance = mcLast || (mode == M_STOP) || (mode == M_WARM); // RULE25

   // ---------------------------------------------------------------
   // Mode sequencer
   // ---------------------------------------------------------------
   always_comb begin
      modeNxt = mode;
      case (mode)
         M_FAST_RUN_SINGLE: begin
            if (ctrl1_r[C1_STOP]) modeNxt = M_STOP;
            else if (ctrl2_r[C2_HALT]) modeNxt = M_TB_HALT_SINGLE; // RULE15
            else if (ctrl2_r[C2_DOZE]) modeNxt = M_FAST_DOZE_SINGLE; // RULE12
            else if (ctrl2_r[C2_SLOWEN]) modeNxt = M_FAST_RUN_DUAL;
         end
         M_FAST_DOZE_SINGLE: begin
            if (irqReq) modeNxt = M_FAST_RUN_SINGLE; // RULE13
         end
         M_TB_HALT_SINGLE: begin
            if (tbFall) modeNxt = retMode_r; // RULE16 RULE17
         end
         M_FAST_RUN_DUAL: begin
            if (ctrl1_r[C1_STOP]) modeNxt = M_STOP;
            else if (ctrl2_r[C2_DOZE]) modeNxt = M_FAST_DOZE_DUAL;
            else if (ctrl2_r[C2_MCS]) modeNxt = M_SLOW_RUN; // RULE23
            else if (!ctrl2_r[C2_SLOWEN]) modeNxt = M_FAST_RUN_SINGLE;
         end
         M_FAST_DOZE_DUAL: begin
            if (irqReq) modeNxt = M_FAST_RUN_DUAL;
         end
         M_SLOW_RUN: begin
            if (ctrl1_r[C1_STOP]) modeNxt = M_STOP;
            else if (ctrl2_r[C2_HALT] && fastOff) begin
               modeNxt = M_TB_HALT_SINGLE;
            end else if (ctrl2_r[C2_DOZE]) modeNxt = M_SLOW_SLEEP;
            else if (!ctrl2_r[C2_MCS] && !fastOff) begin
               modeNxt = M_FAST_RUN_DUAL; // RULE23
            end
         end
         M_SLOW_SLEEP: begin
            if (irqReq) modeNxt = M_SLOW_RUN;
         end
         M_STOP: begin
            if (relS2_r) modeNxt = M_WARM;
         end
         M_WARM: begin
            if (divBits[WARM_TAP]) modeNxt = retMode_r;
         end
         default: modeNxt = M_FAST_RUN_SINGLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode <= M_FAST_RUN_SINGLE; // RULE11
      end else if (advance) begin
         mode <= modeNxt; // RULE25
      end
   end

   // Where halt and stop return to, and what they were entered with
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         retMode_r <= M_FAST_RUN_SINGLE;
         fromFast_r <= 1'b0;
         haltTbEn_r <= 1'b0;
      end else if (advance && modeNxt != mode) begin
         if (modeNxt == M_TB_HALT_SINGLE) begin
            retMode_r <= slowMode ? M_SLOW_RUN : M_FAST_RUN_SINGLE;
            haltTbEn_r <= tbctrl_r[TB_EN]; // RULE18
         end else if (modeNxt == M_STOP) begin
            fromFast_r <= !slowMode; // RULE5
            if (ctrl1_r[C1_RETSLOW]) retMode_r <= M_SLOW_RUN;
            else if (ctrl2_r[C2_SLOWEN]) retMode_r <= M_FAST_RUN_DUAL;
            else retMode_r <= M_FAST_RUN_SINGLE;
         end
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   assign dozeClr = advance && (modeNxt == M_FAST_DOZE_SINGLE ||
      modeNxt == M_FAST_DOZE_DUAL || modeNxt == M_SLOW_SLEEP) &&
      modeNxt != mode;
   assign haltClr = advance && mode == M_TB_HALT_SINGLE && modeNxt != mode;
   assign stopClr = advance && modeNxt == M_STOP && mode != M_STOP;

   // A software write in the same cycle wins over the hardware clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl1_r <= CTRL1_RST;
      end else if (wr1) begin
         ctrl1_r <= bus.wdata;
      end else if (stopClr) begin
         ctrl1_r[C1_STOP] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl2_r <= CTRL2_RST;
      end else if (wr2) begin
         ctrl2_r <= bus.wdata;
      end else begin
         if (dozeClr) ctrl2_r[C2_DOZE] <= 1'b0;
         if (haltClr) ctrl2_r[C2_HALT] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tbctrl_r <= TBCTRL_RST;
      end else if (wrTb) begin
         tbctrl_r <= bus.wdata; // RULE6 RULE7
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= '0;
      end else if (bus.rd) begin
         case (bus.addr)
            ADDR_CTRL1: rdata <= ctrl1_r;
            ADDR_CTRL2: rdata <= ctrl2_r;
            ADDR_TBCTRL: rdata <= tbctrl_r;
            ADDR_STATUS: rdata <= {2'b00, mcState, mode};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Clock enables and oscillator control
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clkEn <= '{cpu: 1'b1, wdt: 1'b1, timebase_timer: 1'b1, periph: 1'b1};
      end else if (advance) begin
         case (modeNxt)
            M_FAST_RUN_SINGLE, M_FAST_RUN_DUAL, M_SLOW_RUN: begin
               clkEn <= '{cpu: 1'b1, wdt: 1'b1, timebase_timer: 1'b1, periph: 1'b1};
            end
            M_FAST_DOZE_SINGLE, M_FAST_DOZE_DUAL, M_SLOW_SLEEP: begin
               clkEn <= '{cpu: 1'b0, wdt: 1'b0, timebase_timer: 1'b1, periph: 1'b1};
            end
            M_TB_HALT_SINGLE: begin
               clkEn <= '{cpu: 1'b0, wdt: 1'b0, timebase_timer: 1'b1, periph: 1'b0};
            end
            default: begin
               clkEn <= '{cpu: 1'b0, wdt: 1'b0, timebase_timer: 1'b0, periph: 1'b0};
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fastOscEnable <= 1'b1;
         slowOscEnable <= 1'b0;
         slowPinsAsPort <= 1'b1;
      end else begin
         fastOscEnable <= (mode != M_STOP) &&
            (!slowMode || ctrl2_r[C2_FASTEN]);
         slowOscEnable <= ctrl2_r[C2_SLOWEN] && mode != M_STOP; // RULE20
         slowPinsAsPort <= !ctrl2_r[C2_SLOWEN]; // RULE10 RULE20
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mainTick <= 1'b0;
         dividerPulseOut <= 1'b0;
      end else begin
         mainTick <= tickNow;
         dividerPulseOut <= divBits[DVO_TAP];
      end
   end

   // ---------------------------------------------------------------
   // Wake-up events
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wakeService <= 1'b0;
         wakeResume <= 1'b0;
         timebaseIrqSet <= 1'b0;
         tbService <= 1'b0;
      end else begin
         wakeService <= dozeExit() && master_interrupt_enable; // RULE14
         wakeResume <= dozeExit() && !master_interrupt_enable; // RULE14
         timebaseIrqSet <= haltClr && haltTbEn_r; // RULE18
         tbService <= haltClr && haltTbEn_r && master_interrupt_enable && tbIrqEnable; // RULE17
      end
   end

   function automatic logic dozeExit();
      return advance && irqReq && (mode == M_FAST_DOZE_SINGLE ||
         mode == M_FAST_DOZE_DUAL || mode == M_SLOW_SLEEP);
   endfunction

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   reset_mode_a: assert property (@(posedge clk) // RULE11
      !rst_n |=> mode == M_FAST_RUN_SINGLE)
      else $error("reset did not select fast run single");
   slow_stage7_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
      slowMode |-> stage7Sel)
      else $error("slow mode stage 7 not from slow clock");
   warm_stage7_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
      (mode == M_WARM && fromFast_r) |-> !stage7Sel)
      else $error("warm-up stage 7 not from stage 6");
   doze_exit_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
      (mode == M_FAST_DOZE_SINGLE && irqReq && mcLast)
      |=> mode == M_FAST_RUN_SINGLE)
      else $error("doze did not end on interrupt");
   doze_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
      (mode == M_FAST_DOZE_SINGLE) |-> !clkEn.cpu && clkEn.periph)
      else $error("doze clock gating wrong");
   halt_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
      (mode == M_TB_HALT_SINGLE) |-> !clkEn.periph && clkEn.timebase_timer)
      else $error("halt clock gating wrong");
   halt_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
      timebaseIrqSet |-> $past(mode) == M_TB_HALT_SINGLE && mode != M_STOP)
      else $error("timebase interrupt set outside halt exit");
   pre_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE24
      (slowMode && fastOff) |-> !preEn)
      else $error("prescaler runs with fast oscillator off");
   mode_edge_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE25
      (mode != $past(mode) && $past(mode) != M_STOP &&
      $past(mode) != M_WARM) |-> $past(mcLast))
      else $error("mode changed off a cycle boundary");
endmodule

// File: verif/scmc_cpu_model.sv
// CPU side model: free running slow oscillator and instruction issue.
// Assumes the controller's clk and its synchronous active-low reset.
module scmc_cpu_model import scmc_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic instrDone,
   input wire logic [1:0] mcState,
   input wire logic [3:0] lenSel,
   output logic slowOscIn,
   output logic instrStart,
   output logic [3:0] instrLen,
   output int lastCycles
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] div = 4'h0;
   logic [1:0] prev = 2'h0;
   logic first = 1'b1;
   int cnt = 0;
   // Slow crystal runs from power-up, so it is stable before use
   assign slowOscIn = div[3];
   initial begin
      instrStart = 1'b0;
      instrLen = 4'h1;
      lastCycles = 0;
   end
   // Next instruction issued as soon as the previous one ends
   always @(posedge clk) begin
      div <= div + 4'h1;
      prev <= mcState;
      first <= !rst_n;
      instrStart <= rst_n && (instrDone || first);
      instrLen <= lenSel;
      cnt <= (instrStart ? 0 : cnt) + int'(prev == 2'h3 && mcState != 2'h3);
      if (instrDone) begin
         lastCycles <= cnt + int'(prev == 2'h3 && mcState != 2'h3);
      end
   end
endmodule

// File: verif/test_system_clock_mode_controller.sv
// Self-checking bench for the clock and mode controller top level.
// Assumes the package and the CPU side model are compiled first.
module test_system_clock_mode_controller import scmc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, irqReq = 0, master_interrupt_enable = 0, tbIrqEnable = 0;
   scmc_bus_t bus = '0;
   logic [3:0] lenSel = 4'hA;
   logic [3:0] instrLen;
   logic [1:0] mcState;
   logic [7:0] rdata, rd, pins;
   scmc_mode_t mode;
   scmc_clken_t clkEn;
   logic slowOscIn, instrStart, instrDone, slowOscEnable, slowPinsAsPort;
   logic wakeService, wakeResume, timebaseIrqSet, tbService, fastOscEnable;
   int lastCycles, n_mismatch = 0, n_checks = 0;
   int nSvc = 0, nRes = 0, nSet = 0, nTb = 0;
   assign pins = {5'h00, fastOscEnable, slowPinsAsPort, slowOscEnable};
   // ---------------------------------------------------------------
   // Design and CPU side
   // ---------------------------------------------------------------
   scmc_top i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .slowOscIn(slowOscIn), .stopReleaseIn(1'b0), .irqReq(irqReq),
      .master_interrupt_enable(master_interrupt_enable), .tbIrqEnable(tbIrqEnable), .instrStart(instrStart),
      .instrLen(instrLen), .mode(mode), .clkEn(clkEn), .mainTick(),
      .mcState(mcState), .instrDone(instrDone), .fastOscEnable(fastOscEnable),
      .slowOscEnable(slowOscEnable), .slowPinsAsPort(slowPinsAsPort),
      .dividerPulseOut(), .timebaseIrqSet(timebaseIrqSet),
      .tbService(tbService), .wakeService(wakeService),
      .wakeResume(wakeResume));
   scmc_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .instrDone(instrDone),
      .mcState(mcState), .lenSel(lenSel), .slowOscIn(slowOscIn),
      .instrStart(instrStart), .instrLen(instrLen),
      .lastCycles(lastCycles));
   // ---------------------------------------------------------------
   // Clock, pulse counters, tasks
   // ---------------------------------------------------------------
   initial begin
      forever #20 clk = ~clk;
   end
   // Pulses are one cycle wide, so count them rather than poll
   always @(posedge clk) begin
      nSvc <= nSvc + int'(wakeService === 1'b1);
      nRes <= nRes + int'(wakeResume === 1'b1);
      nSet <= nSet + int'(timebaseIrqSet === 1'b1);
      nTb <= nTb + int'(tbService === 1'b1);
   end
   task automatic chk(input string what, input logic [7:0] e, s);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rdReg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic waitMode(input scmc_mode_t m, input int lim);
      for (int i = 0; i < lim && mode !== m; i++) begin
         @(posedge clk);
      end
      chk("mode", {4'h0, m}, {4'h0, mode});
   endtask
   task automatic waitDone();
      for (int i = 0; i < 600 && instrDone !== 1'b1; i++) begin
         @(posedge clk);
      end
      @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #3600000;
      n_mismatch++;
      end_of_test();
   end
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("mode", 8'h00, {4'h0, mode});
      chk("clkEn", 8'h0F, {4'h0, clkEn});
      chk("pins", 8'h06, pins);
      rdReg(ADDR_CTRL2, rd);
      chk("ctrl2", CTRL2_RST, rd);
      wrReg(ADDR_TBCTRL, 8'h80);
      rdReg(4'h7, rd);
      chk("unmapped", 8'h00, rd);
      rdReg(ADDR_TBCTRL, rd);
      chk("tbctrl", 8'h80, rd);
      waitDone();
      waitDone();
      chk("cycles", 8'h0A, lastCycles[7:0]);
      lenSel <= 4'h1;
      waitDone();
      waitDone();
      chk("cycles", 8'h01, lastCycles[7:0]);
      for (int k = 1; k >= 0; k--) begin
         master_interrupt_enable <= k[0];
         wrReg(ADDR_CTRL2, 8'h90);
         waitMode(M_FAST_DOZE_SINGLE, 40);
         chk("clkEn", 8'h03, {4'h0, clkEn});
         irqReq <= 1'b1;
         waitMode(M_FAST_RUN_SINGLE, 40);
         irqReq <= 1'b0;
         repeat (3) @(posedge clk);
         chk("wake", k ? 8'h10 : 8'h11, 8'(nSvc * 16 + nRes));
      end
      master_interrupt_enable <= 1'b1;
      tbIrqEnable <= 1'b1;
      wrReg(ADDR_CTRL2, 8'h84);
      waitMode(M_TB_HALT_SINGLE, 40);
      chk("clkEn", 8'h02, {4'h0, clkEn});
      // Timebase tap 0 is a slow divider bit, so allow a long wait
      waitMode(M_FAST_RUN_SINGLE, 40000);
      repeat (3) @(posedge clk);
      chk("tbIrq", 8'h11, 8'(nSet * 16 + nTb));
      wrReg(ADDR_CTRL2, 8'hC0);
      waitMode(M_FAST_RUN_DUAL, 40);
      chk("pins", 8'h05, pins);
      wrReg(ADDR_CTRL2, 8'hE0);
      waitMode(M_SLOW_RUN, 400);
      wrReg(ADDR_CTRL2, 8'h60);
      repeat (2) @(posedge clk);
      chk("pins", 8'h01, pins);
      wrReg(ADDR_CTRL2, 8'hC0);
      waitMode(M_FAST_RUN_DUAL, 400);
      end_of_test();
   end
endmodule
